// file: radio_cfg_pkg.sv
/*
  Shared constants and carriers for the radio turnaround, preamble and
  energy-averaging configuration block.
  Assumes a single 20 MHz baseband clock and a byte-wide register port.
*/
package radio_cfg_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned US_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned STEP_US = 16;
  localparam int unsigned STEP_SHIFT = 4;
  localparam int unsigned TIMER_W = 9;

  // Register addresses
  localparam logic [15:0] TX_FRAME_FORMAT_ADDR = 16'h2215;
  localparam logic [15:0] TURNAROUND_DELAY_ADDR = 16'h2216;
  localparam logic [15:0] GAIN_CTRL_CONFIG_ADDR = 16'h2223;

  // Field positions
  localparam int unsigned TX_TO_RX_LSB = 4;
  localparam int unsigned RX_TO_TX_LSB = 0;
  localparam int unsigned PREAMBLE_LSB = 0;
  localparam int unsigned AVG_WIN_LSB = 3;

  // Reset values
  localparam logic [3:0] TX_TO_RX_RESET = 4'h6;
  localparam logic [3:0] RX_TO_TX_RESET = 4'h1;
  localparam logic [3:0] PREAMBLE_RESET = 4'h3;
  localparam logic [1:0] AVG_WIN_RESET = 2'h0;

  // Preamble symbol offset and averaging base window
  localparam logic [4:0] PREAMBLE_BASE = 5'h06;
  localparam logic [TIMER_W-1:0] AVG_BASE_US = 9'h010;

  // Requests from the modem state machine, all one-cycle pulses
  typedef struct packed {
    logic to_tx;
    logic to_rx;
    logic preamble_start;
    logic meas_start;
  } modem_req_type;

  // Software-visible configuration
  typedef struct packed {
    logic [3:0] tx_to_rx_delay;
    logic [3:0] rx_to_tx_delay;
    logic [3:0] tx_preamble_len;
    logic [1:0] energy_avg_window;
  } cfg_type;

endpackage : radio_cfg_pkg

// file: interval_timer.sv
/*
  Microsecond interval timer: loads a count, runs it down on tick pulses,
  reports busy for exactly that many ticks and a done pulse afterwards.
  Assumes tick is a one-cycle enable from a divider on the same clock.
*/
`timescale 1ns/1ns
module interval_timer #(
  parameter int unsigned W = 9
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Control
  input wire logic start,
  input wire logic [W-1:0] load,
  input wire logic tick,
  // Status
  output logic busy,
  output logic done
);

  // Refuse widths too narrow for a count and its zero test
  if (W < 2) begin : g_w_check
    $error("interval_timer: W too small");
  end

  logic [W-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  // A zero load finishes at once; start ignored while running
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start && !busy_q) begin
      cnt_d = load;
      busy_d = (load != '0);
      done_d = (load == '0);
    end else if (busy_q && tick) begin
      cnt_d = cnt_q - 1'b1;
      if (cnt_q == W'(1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule : interval_timer

// file: radio_turnaround_preamble_cfg.sv
/*
  Turnaround delay, transmit preamble length and energy-averaging window
  for the baseband modem, with their byte-wide software registers.
  Assumes the modem sends one-cycle requests and one energy sample per
  microsecond is valid on energy_sample whenever a measurement runs.
*/
// Local design decision: the strobed register port.
// Overview of operation
// - Receive-to-transmit waits the 4-bit rx_to_tx_delay field times 16 us, 0 to 240 us.
// - Transmit-to-receive waits the 4-bit tx_to_rx_delay field times 16 us, 0 to 240 us.
// - The tx_to_rx_delay field sits in bits 7:4, resets to 0110 and counts in 16 us steps.
// - A tx_preamble_len value n gives a preamble of n+6 symbols, 6 to 21.
// - Energy is averaged over a window set by a 2-bit field, code 0 is 16 us and code 1 is 32 us.
`timescale 1ns/1ns
module radio_turnaround_preamble_cfg (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Modem requests and energy samples
  input wire radio_cfg_pkg::modem_req_type modem_req,
  input wire logic [7:0] energy_sample,
  // Turnaround results
  output logic turnaround_busy,
  output logic enter_tx,
  output logic enter_rx,
  // Preamble timing
  output logic preamble_active,
  output logic preamble_done,
  // Energy averaging
  output logic meas_busy,
  output logic avg_valid,
  output logic [7:0] avg_energy
);

  localparam int unsigned TW = radio_cfg_pkg::TIMER_W;
  localparam int unsigned SUM_W = 16;

  // The tick divider is five bits wide, so the cycles per microsecond must fit
  if (radio_cfg_pkg::US_CYCLES < 2 || radio_cfg_pkg::US_CYCLES > 32) begin : g_us_check
    $error("clock rate unusable for the microsecond tick");
  end

  radio_cfg_pkg::cfg_type cfg_q, cfg_d;
  logic [7:0] rdata_q, rdata_d;

  // Register writes; reserved bits are not stored
  always_comb begin
    cfg_d = cfg_q;
    if (reg_wr) begin
      case (reg_addr)
        radio_cfg_pkg::TURNAROUND_DELAY_ADDR: begin
          cfg_d.tx_to_rx_delay = reg_wdata[radio_cfg_pkg::TX_TO_RX_LSB +: 4];
          cfg_d.rx_to_tx_delay = reg_wdata[radio_cfg_pkg::RX_TO_TX_LSB +: 4];
        end
        radio_cfg_pkg::TX_FRAME_FORMAT_ADDR: begin
          cfg_d.tx_preamble_len = reg_wdata[radio_cfg_pkg::PREAMBLE_LSB +: 4];
        end
        radio_cfg_pkg::GAIN_CTRL_CONFIG_ADDR: begin
          cfg_d.energy_avg_window = reg_wdata[radio_cfg_pkg::AVG_WIN_LSB +: 2];
        end
        default: begin
          cfg_d = cfg_q;
        end
      endcase
    end
  end

  // Read data stands for one cycle only; unmapped and reserved read zero
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        radio_cfg_pkg::TURNAROUND_DELAY_ADDR: begin
          rdata_d[radio_cfg_pkg::TX_TO_RX_LSB +: 4] = cfg_q.tx_to_rx_delay;
          rdata_d[radio_cfg_pkg::RX_TO_TX_LSB +: 4] = cfg_q.rx_to_tx_delay;
        end
        radio_cfg_pkg::TX_FRAME_FORMAT_ADDR: begin
          rdata_d[radio_cfg_pkg::PREAMBLE_LSB +: 4] = cfg_q.tx_preamble_len;
        end
        radio_cfg_pkg::GAIN_CTRL_CONFIG_ADDR: begin
          rdata_d[radio_cfg_pkg::AVG_WIN_LSB +: 2] = cfg_q.energy_avg_window;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // Register file
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_q.tx_to_rx_delay <= radio_cfg_pkg::TX_TO_RX_RESET;
      cfg_q.rx_to_tx_delay <= radio_cfg_pkg::RX_TO_TX_RESET;
      cfg_q.tx_preamble_len <= radio_cfg_pkg::PREAMBLE_RESET;
      cfg_q.energy_avg_window <= radio_cfg_pkg::AVG_WIN_RESET;
      rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Microsecond tick divider; free-running, so a delay may end up to
  // one tick early, which is well inside a 16 us step
  localparam logic [4:0] US_LAST = 5'(radio_cfg_pkg::US_CYCLES - 1);
  logic [4:0] div_q, div_d;
  logic us_tick;

  always_comb begin
    div_d = (div_q == US_LAST) ? 5'h00 : div_q + 5'h01;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_d;
    end
  end

  assign us_tick = (div_q == US_LAST);

  // Turnaround: delay is latched at the request, so later writes wait
  logic turn_start;
  logic turn_dir_tx_q, turn_dir_tx_d;
  logic [TW-1:0] turn_load;
  logic turn_busy, turn_done;
  logic enter_tx_q, enter_tx_d, enter_rx_q, enter_rx_d;

  assign turn_start = (modem_req.to_tx || modem_req.to_rx) && !turn_busy;

  always_comb begin
    turn_dir_tx_d = turn_dir_tx_q;
    turn_load = '0;
    enter_tx_d = turn_done && turn_dir_tx_q;
    enter_rx_d = turn_done && !turn_dir_tx_q;
    if (modem_req.to_tx) begin
      turn_load = {1'b0, cfg_q.rx_to_tx_delay, 4'h0};
    end else begin
      turn_load = {1'b0, cfg_q.tx_to_rx_delay, 4'h0};
    end
    if (turn_start) begin
      turn_dir_tx_d = modem_req.to_tx; // Transmit wins if both asked at once
    end
  end

  interval_timer #(
    .W(TW)
  ) turn_timer (
    .mclk(mclk),
    .srst(srst),
    .start(turn_start),
    .load(turn_load),
    .tick(us_tick),
    .busy(turn_busy),
    .done(turn_done)
  );

  // Preamble of n+6 symbols, 16 us each
  logic [4:0] pre_symbols;
  logic [TW-1:0] pre_load;

  assign pre_symbols = 5'(cfg_q.tx_preamble_len) + radio_cfg_pkg::PREAMBLE_BASE;
  assign pre_load = {pre_symbols, 4'h0};

  interval_timer #(
    .W(TW)
  ) pre_timer (
    .mclk(mclk),
    .srst(srst),
    .start(modem_req.preamble_start),
    .load(pre_load),
    .tick(us_tick),
    .busy(preamble_active),
    .done(preamble_done)
  );

  // Energy averaging over 16, 32, 64 or 128 us, window latched at start
  logic meas_start;
  logic [TW-1:0] meas_load;
  logic meas_run, meas_done;
  logic [1:0] win_q, win_d;
  logic [SUM_W-1:0] sum_q, sum_d;
  logic [7:0] avg_q, avg_d;
  logic avg_valid_q, avg_valid_d;
  logic [SUM_W-1:0] shifted;

  assign meas_start = modem_req.meas_start && !meas_run;
  assign meas_load = radio_cfg_pkg::AVG_BASE_US << cfg_q.energy_avg_window;
  assign shifted = sum_q >> (radio_cfg_pkg::STEP_SHIFT + win_q);

  always_comb begin
    win_d = win_q;
    sum_d = sum_q;
    avg_d = avg_q;
    avg_valid_d = 1'b0;
    if (meas_start) begin
      win_d = cfg_q.energy_avg_window;
      sum_d = '0;
    end else if (meas_run && us_tick) begin
      sum_d = sum_q + SUM_W'(energy_sample);
    end
    if (meas_done) begin
      avg_d = shifted[7:0];
      avg_valid_d = 1'b1;
    end
  end

  interval_timer #(
    .W(TW)
  ) meas_timer (
    .mclk(mclk),
    .srst(srst),
    .start(meas_start),
    .load(meas_load),
    .tick(us_tick),
    .busy(meas_run),
    .done(meas_done)
  );

  // Direction, accumulator and result registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      turn_dir_tx_q <= 1'b0;
      enter_tx_q <= 1'b0;
      enter_rx_q <= 1'b0;
      win_q <= 2'h0;
      sum_q <= '0;
      avg_q <= 8'h00;
      avg_valid_q <= 1'b0;
    end else begin
      turn_dir_tx_q <= turn_dir_tx_d;
      enter_tx_q <= enter_tx_d;
      enter_rx_q <= enter_rx_d;
      win_q <= win_d;
      sum_q <= sum_d;
      avg_q <= avg_d;
      avg_valid_q <= avg_valid_d;
    end
  end

  assign turnaround_busy = turn_busy;
  assign enter_tx = enter_tx_q;
  assign enter_rx = enter_rx_q;
  assign meas_busy = meas_run;
  assign avg_energy = avg_q;
  assign avg_valid = avg_valid_q;

endmodule : radio_turnaround_preamble_cfg

// file: radio_cfg_chk.sv
/*
  Port checks for the turnaround, preamble and averaging block.
  Assumes one clock mclk and a synchronous active-high srst.
*/
`timescale 1ns/1ns
module radio_cfg_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Modem side
  input wire radio_cfg_pkg::modem_req_type modem_req,
  input wire logic turnaround_busy,
  input wire logic enter_tx,
  input wire logic enter_rx,
  input wire logic preamble_active,
  input wire logic preamble_done,
  input wire logic meas_busy,
  input wire logic avg_valid,
  input wire logic [7:0] avg_energy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Window closes: busy one cycle, then low
  sequence meas_end_s;
    meas_busy ##1 !meas_busy;
  endsequence
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  tx_pulse_a: assert property (enter_tx |=> !enter_tx)
    else $error("enter_tx longer than one cycle");
  one_dir_a: assert property (!(enter_tx && enter_rx))
    else $error("both directions at once");
  ta_idle_a: assert property ((enter_tx || enter_rx) |-> !$past(turnaround_busy))
    else $error("turnaround ended while busy");
  pre_start_a: assert property (modem_req.preamble_start && !preamble_active |=> preamble_active)
    else $error("preamble did not start");
  pre_done_a: assert property (preamble_done == $fell(preamble_active))
    else $error("preamble done not at end");
  meas_start_a: assert property (modem_req.meas_start && !meas_busy |=> meas_busy)
    else $error("measurement did not start");
  avg_valid_a: assert property (meas_end_s |=> avg_valid)
    else $error("average not flagged after window");
  avg_hold_a: assert property (!avg_valid |-> $stable(avg_energy))
    else $error("average changed without flag");
endmodule : radio_cfg_chk

bind radio_turnaround_preamble_cfg radio_cfg_chk chk_u (.mclk, .srst, .reg_rd, .reg_rdata,
  .modem_req, .turnaround_busy, .enter_tx, .enter_rx, .preamble_active, .preamble_done,
  .meas_busy, .avg_valid, .avg_energy);

// file: test_radio_turnaround_preamble_cfg.sv
/*
  Self-checking bench for the configuration block.
  Assumes the package is compiled first and the checker is bound.
*/
`timescale 1ns/1ns
module test_radio_turnaround_preamble_cfg;
  logic mclk, srst, reg_wr, reg_rd, rd_q;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, energy_sample, avg_energy;
  radio_cfg_pkg::modem_req_type modem_req;
  logic turnaround_busy, enter_tx, enter_rx, preamble_active, preamble_done, meas_busy, avg_valid;
  logic [7:0] exp_q[$];
  logic [31:0] rnd;
  int err_total, tests_run, n;

  radio_turnaround_preamble_cfg dut_u (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .modem_req, .energy_sample, .turnaround_busy, .enter_tx, .enter_rx,
    .preamble_active, .preamble_done, .meas_busy, .avg_valid, .avg_energy);

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task end_of_test();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task cmp(input string nm, input logic [7:0] s);
    logic [7:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 8'hXX;
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task rng(input string nm, input int lo, input int hi, input int v);
    tests_run++;
    if (v < lo || v > hi) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d to %0d seen %0d", nm, lo, hi, v);
    end
  endtask : rng

  // One bus cycle; a read notes its expected byte
  task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : bus

  task pulse(input logic [3:0] r);
    @(posedge mclk);
    modem_req <= r;
    @(posedge mclk);
    modem_req <= '0;
  endtask : pulse

  // Bounded wait, counting cycles after the request
  task wt(input int k);
    n = 0;
    while (!(k == 0 ? enter_tx : k == 1 ? enter_rx : k == 2 ? preamble_done : avg_valid)) begin
      @(posedge mclk);
      n++;
      if (n > 9000) begin
        err_total++;
        end_of_test();
      end
    end
  endtask : wt

  // Results are matched in the order the driver noted them
  always @(posedge mclk) begin
    rd_q <= reg_rd;
    if (rd_q === 1'b1) cmp("reg_rdata", reg_rdata);
    if (avg_valid === 1'b1) cmp("avg_energy", avg_energy);
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, energy_sample} = '0;
    modem_req = '0;
    rnd = 32'hB7DE;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    bus(0, 16'h2216, 8'h61);
    bus(0, 16'h2215, 8'h03);
    bus(0, 16'h2223, 8'h00);
    bus(0, 16'h2217, 8'h00);
    // Random values; reserved bits and unmapped place read zero
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      bus(1, 16'h2216, rnd[7:0]);
      bus(1, 16'h2215, rnd[15:8]);
      bus(1, 16'h2223, rnd[23:16]);
      bus(1, 16'h2217, rnd[31:24]);
      bus(0, 16'h2216, rnd[7:0]);
      bus(0, 16'h2215, rnd[15:8] & 8'h0F);
      bus(0, 16'h2223, rnd[23:16] & 8'h18);
      bus(0, 16'h2217, 8'h00);
    end
    // Turnarounds: zero, one step with a refused request, maximum
    bus(1, 16'h2216, 8'h10);
    pulse(4'h8);
    wt(0);
    rng("rx_to_tx zero", 2, 2, n);
    pulse(4'h4);
    pulse(4'h8);
    wt(1);
    rng("tx_to_rx one", 300, 323, n + 2);
    bus(1, 16'h2216, 8'h0F);
    pulse(4'h8);
    wt(0);
    rng("rx_to_tx max", 4780, 4803, n);
    // Longest preamble, rewritten mid-way, then shortest
    bus(1, 16'h2215, 8'h0F);
    pulse(4'h2);
    bus(1, 16'h2215, 8'h00);
    wt(2);
    rng("preamble 21", 6700, 6723, n + 2);
    pulse(4'h2);
    wt(2);
    rng("preamble 6", 1900, 1923, n);
    // Recommended setting, kept equal on the receive side by software
    bus(1, 16'h2215, 8'h02);
    bus(0, 16'h2215, 8'h02);
    pulse(4'h2);
    wt(2);
    rng("preamble 8", 2540, 2563, n);
    // Every averaging code with a steady sample
    for (int c = 0; c < 4; c++) begin
      rnd = lfsr(rnd);
      bus(1, 16'h2223, {3'h0, c[1:0], 3'h0});
      energy_sample <= rnd[7:0];
      exp_q.push_back(rnd[7:0]);
      pulse(4'h1);
      wt(3);
      rng("window", (16 << c) * 20 - 20, (16 << c) * 20 + 3, n);
    end
    repeat (4) @(posedge mclk);
    end_of_test();
  end
endmodule : test_radio_turnaround_preamble_cfg
